// file: rtl/spim_master.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`default_nettype none
// Functional notes
// - transmit and receive each have a one-byte holding stage behind them.
// - no chip-select output exists; software selects the slave elsewhere.
// - all four polarity/phase modes are supported.
// - a disconnected clock or mosi select leaves that signal off every pin; miso is read from its pin number even when disconnected.
// - pin selects act only while enabled.
// - disabling does not reset registers; software programs them all.
// - writing transmit data starts a transfer.
// - a second byte goes out after the first, in order; written in the idle cycle before the start, it replaces the first.
// - every byte sent also receives one into receive data or the waiting byte.
// - a second received byte waits while the first is unread.
// - byte-done rises each time receive data is loaded.
// - waiting byte moves in when current is read; its event then.
// - clocking stops when transmit stage and holding stage are empty.
// - receive load and event come a short delay after last bit.
// - writing 1 to irq-enable-set bit 0 enables; 0 does nothing.
// - enable field 0 disables, 1 enables the controller.
// - bit rate one-hot, 125 kbps to 8 Mbps, doubling per step.
// - bit order 0 sends MSB first, 1 sends LSB first.
// - phase 0 samples leading, shifts trailing; phase 1 the reverse.
module spim_master (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [31:0] pinIn,
    output logic      [31:0] pinOut,
    output logic      [31:0] pinOe,
    output logic             irq
);
    logic [31:0]  enable_q;
    logic         irqEn_q;
    logic         event_q;
    logic [31:0]  pselClk_q;
    logic [31:0]  pselMosi_q;
    logic [31:0]  pselMiso_q;
    logic [31:0]  rate_q;
    spim_pkg::spim_shape_t shape_q;
    logic [7:0]   txHold_q;
    logic         txHoldValid_q;
    logic [7:0]   txNext_q;
    logic         txNextValid_q;
    logic [7:0]   rxData_q;
    logic [7:0]   rxWait_q;
    logic         rxWaitValid_q;
    logic [7:0]   rxShift_q;
    logic [7:0]   txShift_q;
    logic [2:0]   bitCnt_q;
    logic         sck_q;
    logic         mosi_q;
    logic [31:0]  halfCnt_q;
    logic [7:0]   loadCnt_q;
    logic [1:0]   misoSync_q;
    spim_pkg::spim_state_t state_q;

    // bus address phase capture
    logic         wrPend_q;
    logic         rdPend_q;
    logic [11:0]  addr_q;
    logic         accept;
    logic         active;
    logic         wrTx;
    logic         rdRx;
    logic [31:0]  halfLen;
    logic         misoPin;
    logic         sampleEdge;
    logic         halfDone;
    logic         rxDone;

    assign accept = hsel && hready && htrans[1];
    assign active = enable_q[0];
    assign wrTx   = wrPend_q && addr_q == spim_pkg::OFF_TXDATA;
    assign rdRx   = rdPend_q && addr_q == spim_pkg::OFF_RXDATA;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q   <= 12'h000;
        end else begin
            wrPend_q <= accept && hwrite;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                addr_q <= haddr[11:0];
            end
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data registered in the address phase so it stands in the data phase
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hrdata <= 32'h00000000;
        end else if (accept && !hwrite) begin
            if (haddr[11:0] == spim_pkg::OFF_EVENT) begin
                hrdata <= {31'h00000000, event_q};
            end else if (haddr[11:0] == spim_pkg::OFF_IRQSET
                         || haddr[11:0] == spim_pkg::OFF_IRQCLR) begin
                hrdata <= {31'h00000000, irqEn_q};
            end else if (haddr[11:0] == spim_pkg::OFF_ENABLE) begin
                hrdata <= enable_q;
            end else if (haddr[11:0] == spim_pkg::OFF_PSELCLK) begin
                hrdata <= pselClk_q;
            end else if (haddr[11:0] == spim_pkg::OFF_PSELMO) begin
                hrdata <= pselMosi_q;
            end else if (haddr[11:0] == spim_pkg::OFF_PSELMI) begin
                hrdata <= pselMiso_q;
            end else if (haddr[11:0] == spim_pkg::OFF_RXDATA) begin
                hrdata <= {24'h000000, rxData_q};
            end else if (haddr[11:0] == spim_pkg::OFF_TXDATA) begin
                hrdata <= {24'h000000, txHold_q};
            end else if (haddr[11:0] == spim_pkg::OFF_RATE) begin
                hrdata <= rate_q;
            end else if (haddr[11:0] == spim_pkg::OFF_SHAPE) begin
                hrdata <= {29'h00000000, shape_q};
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // configuration; disabling leaves every register untouched
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enable_q   <= 32'h00000000;
            pselClk_q  <= spim_pkg::PSEL_RESET;
            pselMosi_q <= spim_pkg::PSEL_RESET;
            pselMiso_q <= spim_pkg::PSEL_RESET;
            rate_q     <= spim_pkg::RATE_RESET;
            shape_q    <= '0;
            irqEn_q    <= 1'b0;
        end else if (wrPend_q) begin
            if (addr_q == spim_pkg::OFF_ENABLE) begin
                enable_q <= {31'h00000000, hwdata[0]};
            end else if (addr_q == spim_pkg::OFF_PSELCLK) begin
                pselClk_q <= hwdata;
            end else if (addr_q == spim_pkg::OFF_PSELMO) begin
                pselMosi_q <= hwdata;
            end else if (addr_q == spim_pkg::OFF_PSELMI) begin
                pselMiso_q <= hwdata;
            end else if (addr_q == spim_pkg::OFF_RATE) begin
                rate_q <= hwdata;
            end else if (addr_q == spim_pkg::OFF_SHAPE) begin
                shape_q <= hwdata[2:0];
            end else if (addr_q == spim_pkg::OFF_IRQSET && hwdata[0]) begin
                irqEn_q <= 1'b1;
            end else if (addr_q == spim_pkg::OFF_IRQCLR && hwdata[0]) begin
                irqEn_q <= 1'b0;
            end
        end
    end

    // half bit length from the one-hot rate; no rate bit set falls to slowest, several set pick the highest
    always_comb begin
        halfLen = spim_pkg::HALF_BIT_MIN << 6;
        for (int i = 0; i < 7; i++) begin
            if (rate_q[spim_pkg::RATE_LOW_BIT + i]) begin
                halfLen = spim_pkg::HALF_BIT_MIN << (6 - i);
            end
        end
    end

    // the selected miso pin, synchronised before use
    assign misoPin = pinIn[pselMiso_q[4:0]];
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            misoSync_q <= 2'b00;
        end else begin
            misoSync_q <= {misoSync_q[0], misoPin};
        end
    end

    assign halfDone   = halfCnt_q >= halfLen - 32'd1;
    // sck_q equals cpol at the leading edge of each bit
    assign sampleEdge = (sck_q == shape_q.cpol) ^ shape_q.cpha;
    assign rxDone     = state_q == spim_pkg::SPIM_LOAD
                        && loadCnt_q >= 8'(spim_pkg::RX_LOAD_CYC - 1);

    // transmit buffers: holding register plus one queued byte
    // a third write while both are full replaces the queued byte, or the holding byte in the idle cycle before a start
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txHold_q      <= 8'h00;
            txHoldValid_q <= 1'b0;
            txNext_q      <= 8'h00;
            txNextValid_q <= 1'b0;
        end else begin
            if (wrTx) begin
                if (!txHoldValid_q || (state_q == spim_pkg::SPIM_IDLE && active)) begin
                    txHold_q      <= hwdata[7:0];
                    txHoldValid_q <= 1'b1;
                end else begin
                    txNext_q      <= hwdata[7:0];
                    txNextValid_q <= 1'b1;
                end
            end else if (state_q == spim_pkg::SPIM_IDLE && active && txHoldValid_q) begin
                txHold_q      <= txNext_q;
                txHoldValid_q <= txNextValid_q;
                txNextValid_q <= 1'b0;
            end
        end
    end

    // shifter state machine
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q   <= spim_pkg::SPIM_IDLE;
            sck_q     <= 1'b0;
            mosi_q    <= 1'b0;
            halfCnt_q <= 32'h00000000;
            bitCnt_q  <= 3'h0;
            txShift_q <= 8'h00;
            rxShift_q <= 8'h00;
            loadCnt_q <= 8'h00;
        end else begin
            case (state_q)
                spim_pkg::SPIM_IDLE: begin
                    sck_q     <= shape_q.cpol;
                    halfCnt_q <= 32'h00000000;
                    if (active && txHoldValid_q && !wrTx) begin
                        state_q   <= spim_pkg::SPIM_SHIFT;
                        bitCnt_q  <= 3'h0;
                        txShift_q <= txHold_q;
                        // first bit out before the first edge when phase is 0
                        mosi_q    <= shape_q.lsbFirst ? txHold_q[0] : txHold_q[7];
                    end
                end
                spim_pkg::SPIM_SHIFT: begin
                    halfCnt_q <= halfDone ? 32'h00000000 : halfCnt_q + 32'd1;
                    if (halfDone) begin
                        sck_q <= !sck_q;
                        if (sampleEdge) begin
                            rxShift_q <= shape_q.lsbFirst
                                ? {misoSync_q[1], rxShift_q[7:1]}
                                : {rxShift_q[6:0], misoSync_q[1]};
                        end
                        if (!shape_q.cpha && sampleEdge) begin
                            txShift_q <= shape_q.lsbFirst ? {1'b0, txShift_q[7:1]}
                                                          : {txShift_q[6:0], 1'b0};
                        end else if (!shape_q.cpha) begin
                            // phase 0 puts each next bit out on the trailing edge
                            mosi_q <= shape_q.lsbFirst ? txShift_q[0] : txShift_q[7];
                        end else if (shape_q.cpha && !sampleEdge) begin
                            mosi_q    <= shape_q.lsbFirst ? txShift_q[0] : txShift_q[7];
                            txShift_q <= shape_q.lsbFirst ? {1'b0, txShift_q[7:1]}
                                                          : {txShift_q[6:0], 1'b0};
                        end
                        // trailing edge ends a bit
                        if (sck_q != shape_q.cpol) begin
                            bitCnt_q <= bitCnt_q + 3'h1;
                            if (bitCnt_q == 3'h7) begin
                                state_q   <= spim_pkg::SPIM_LOAD;
                                loadCnt_q <= 8'h00;
                            end
                        end
                    end
                end
                spim_pkg::SPIM_LOAD: begin
                    loadCnt_q <= loadCnt_q + 8'h01;
                    mosi_q    <= 1'b0;
                    // keep the byte here while a byte waits and the event is set
                    if (rxDone && !(rxWaitValid_q && event_q)) begin
                        state_q <= spim_pkg::SPIM_IDLE;
                    end
                end
                default: begin
                    state_q <= spim_pkg::SPIM_IDLE;
                end
            endcase
        end
    end

    // receive path: data register plus one waiting byte; event set beats clear
    // a full receive side stalls the shifter while the event is set; with the event cleared the waiting byte is overwritten
    logic rxLoadNow;
    logic rxFull_q;
    assign rxLoadNow = rxDone && !(rxWaitValid_q && event_q);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rxData_q      <= 8'h00;
            rxWait_q      <= 8'h00;
            rxWaitValid_q <= 1'b0;
            rxFull_q      <= 1'b0;
            event_q       <= 1'b0;
        end else begin
            if (wrPend_q && addr_q == spim_pkg::OFF_EVENT) begin
                event_q <= hwdata[0];
            end
            if (rdRx && rxWaitValid_q) begin
                rxData_q      <= rxWait_q;
                rxWaitValid_q <= 1'b0;
                event_q       <= 1'b1;
            end else if (rdRx) begin
                rxFull_q <= 1'b0;
            end
            if (rxLoadNow) begin
                if (rxFull_q && !rdRx || rxWaitValid_q && rdRx) begin
                    rxWait_q      <= rxShift_q;
                    rxWaitValid_q <= 1'b1;
                end else begin
                    rxData_q <= rxShift_q;
                    rxFull_q <= 1'b1;
                    event_q  <= 1'b1;
                end
            end
        end
    end

    // pin routing; no chip select is produced
    // next pin words built whole, so a pin never glitches within one edge
    logic [31:0] pinOut_d;
    logic [31:0] pinOe_d;

    always_comb begin
        pinOut_d = 32'h00000000;
        pinOe_d  = 32'h00000000;
        if (active) begin
            if (!pselClk_q[spim_pkg::PSEL_CONNECT_BIT]) begin
                pinOut_d[pselClk_q[4:0]] = sck_q;
                pinOe_d[pselClk_q[4:0]]  = 1'b1;
            end
            if (!pselMosi_q[spim_pkg::PSEL_CONNECT_BIT]) begin
                pinOut_d[pselMosi_q[4:0]] = mosi_q;
                pinOe_d[pselMosi_q[4:0]]  = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pinOut <= 32'h00000000;
            pinOe  <= 32'h00000000;
            irq    <= 1'b0;
        end else begin
            pinOut <= pinOut_d;
            pinOe  <= pinOe_d;
            irq    <= event_q && irqEn_q;
        end
    end
endmodule : spim_master
`default_nettype wire

// file: shared/spim_pkg.sv
`default_nettype none
package spim_pkg;
    localparam logic [11:0] OFF_EVENT   = 12'h108;
    localparam logic [11:0] OFF_IRQSET  = 12'h304;
    localparam logic [11:0] OFF_IRQCLR  = 12'h308;
    localparam logic [11:0] OFF_ENABLE  = 12'h500;
    localparam logic [11:0] OFF_PSELCLK = 12'h508;
    localparam logic [11:0] OFF_PSELMO  = 12'h50C;
    localparam logic [11:0] OFF_PSELMI  = 12'h510;
    localparam logic [11:0] OFF_RXDATA  = 12'h518;
    localparam logic [11:0] OFF_TXDATA  = 12'h51C;
    localparam logic [11:0] OFF_RATE    = 12'h524;
    localparam logic [11:0] OFF_SHAPE   = 12'h554;

    localparam int          PSEL_CONNECT_BIT = 31;
    localparam logic [31:0] PSEL_RESET       = 32'hFFFFFFFF;
    localparam logic [31:0] RATE_RESET       = 32'h04000000;
    localparam int          RATE_LOW_BIT     = 25;
    localparam int          SHAPE_ORDER_BIT  = 0;
    localparam int          SHAPE_CPHA_BIT   = 1;
    localparam int          SHAPE_CPOL_BIT   = 2;

    // sys_clk cycles per half bit at 8 Mbps; each slower rate step doubles this
    localparam int          CLK_MHZ        = 125;
    localparam int          FASTEST_KBPS   = 8000;
    localparam int          HALF_BIT_MIN   = (CLK_MHZ * 1000) / (FASTEST_KBPS * 2);
    // delay from last bit period to receive load
    localparam int          RX_LOAD_NS     = 16;
    localparam int          RX_LOAD_CYC    = (RX_LOAD_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        SPIM_IDLE  = 2'b00,
        SPIM_SHIFT = 2'b01,
        SPIM_LOAD  = 2'b10
    } spim_state_t;

    typedef struct packed {
        logic       cpol;
        logic       cpha;
        logic       lsbFirst;
    } spim_shape_t;
endpackage : spim_pkg
`default_nettype wire

// file: verif/spim_master_sva.sv
`default_nettype none
module spim_master_sva (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] pinOe,
    input wire logic        irq
);
    logic        ap_q;
    logic        aw_q;
    logic [11:0] aa_q;
    logic        en_q;
    logic        ien_q;
    logic [2:0]  shp_q;
    wire  logic  take = hsel && hready && htrans[1];
    wire  logic  rdOf = take && !hwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    always_ff @(posedge sys_clk) begin
        ap_q <= !reset && take;
        aa_q <= haddr[11:0];
        aw_q <= hwrite;
    end
    // shadows of what software wrote, seen from the bus only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            en_q  <= 1'b0;
            ien_q <= 1'b0;
            shp_q <= 3'h0;
        end else if (ap_q && aw_q && hready) begin
            if (aa_q == spim_pkg::OFF_ENABLE) en_q <= hwdata[0];
            if (aa_q == spim_pkg::OFF_IRQSET && hwdata[0]) ien_q <= 1'b1;
            if (aa_q == spim_pkg::OFF_IRQCLR && hwdata[0]) ien_q <= 1'b0;
            if (aa_q == spim_pkg::OFF_SHAPE) shp_q <= hwdata[2:0];
        end
    end
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    chk_unmapped_zero: assert property (rdOf && haddr[11:8] == 4'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_shape_read: assert property (rdOf && haddr[11:0] == spim_pkg::OFF_SHAPE
        |=> hrdata[2:0] == $past(shp_q)) else $error("shape readback wrong");
    chk_ien_read: assert property (rdOf && (haddr[11:0] == spim_pkg::OFF_IRQSET
        || haddr[11:0] == spim_pkg::OFF_IRQCLR) |=> hrdata[0] == $past(ien_q))
        else $error("irq enable readback wrong");
    chk_irq_needs_en: assert property (irq |-> $past(ien_q))
        else $error("irq without enable");
    chk_irq_drop: assert property ($fell(ien_q) |-> ##[0:2] !irq)
        else $error("irq stays after disable");
    chk_pins_off: assert property (!$past(en_q) && !$past(en_q, 2) |-> pinOe == 32'h0)
        else $error("pins driven while disabled");
    chk_two_pins: assert property ($countones(pinOe) <= 2)
        else $error("more than clock and data driven");
    cover property ($rose(irq));
    cover property (rdOf && haddr[11:0] == spim_pkg::OFF_SHAPE);
    cover property (take && hwrite && haddr[11:0] == spim_pkg::OFF_TXDATA);
endmodule : spim_master_sva
bind spim_master spim_master_sva i_spim_master_sva (.sys_clk(sys_clk), .reset(reset),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pinOe(pinOe), .irq(irq));
`default_nettype wire

// file: verif/spim_slave_model.sv
`default_nettype none
module spim_slave_model (
    input  wire logic       sRst,
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic [2:0] shape,
    input  wire logic [7:0] base,
    output logic            miso,
    output logic      [7:0] rxLast,
    output logic      [7:0] rxPrev
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] nSam;
    logic [2:0] nSh;
    logic [2:0] idx;
    logic [7:0] cnt;
    logic [7:0] rxSh;
    logic [7:0] tx;
    // reset held over enable, as the idle level may jump then
    always @(sck or posedge sRst) begin
        if (sRst) begin
            nSam = 3'h0;
            nSh = 3'h0;
            cnt = 8'h0;
            rxLast = 8'h0;
            rxPrev = 8'h0;
        end else if ((sck !== shape[2]) != shape[1]) begin
            rxSh = shape[0] ? {mosi, rxSh[7:1]} : {rxSh[6:0], mosi};
            nSam = nSam + 3'h1;
            if (nSam == 3'h0) begin
                rxPrev = rxLast;
                rxLast = rxSh;
                cnt = cnt + 8'h1;
            end
        end else begin
            nSh = nSh + 3'h1;
        end
    end
    always_comb begin
        tx = base + cnt;
        idx = shape[1] ? nSh - 3'h1 : nSh;
        miso = tx[shape[0] ? idx : 3'h7 - idx];
    end
endmodule : spim_slave_model
`default_nettype wire

// file: verif/test_spi_master_double_buffered.sv
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t: got %0h want %0h", $time, a, e); end end
module test_spi_master_double_buffered;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] RA [7] = '{spim_pkg::OFF_EVENT, spim_pkg::OFF_IRQSET,
        spim_pkg::OFF_ENABLE, spim_pkg::OFF_PSELCLK, spim_pkg::OFF_RATE, spim_pkg::OFF_SHAPE,
        12'h040};
    localparam logic [31:0] RV [7] = '{32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h04000000,
        32'h0, 32'h0};
    logic        sys_clk;
    logic        reset;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] pinIn;
    logic [31:0] pinOut;
    logic [31:0] pinOe;
    logic        irq;
    logic [31:0] noise;
    logic [2:0]  shape;
    logic        sRst;
    logic        miso;
    logic [7:0]  base;
    logic [7:0]  rxLast;
    logic [7:0]  rxPrev;
    logic [31:0] d;
    logic [7:0]  b1;
    logic [7:0]  b2;
    int          num_errors;
    int          checks;
    int          n8;
    int          n1;
    // clock and data read back on their own pins: clock input buffer kept on
    assign pinIn = {noise[31:6], miso, pinOut[4:3], noise[2:0]};
    spim_master i_spim_master (.sys_clk(sys_clk), .reset(reset), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
    spim_slave_model i_spim_slave_model (.sRst(sRst), .sck(pinOut[3]), .mosi(pinOut[4]),
        .shape(shape), .base(base), .miso(miso), .rxLast(rxLast), .rxPrev(rxPrev));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus
    task automatic wait_ev();
        d = 32'h0;
        for (int k = 0; k < 3000 && d[0] !== 1'b1; k++) bus(1'b0, spim_pkg::OFF_EVENT, 32'h0);
        `CHK(d[0], 1'b1)
    endtask : wait_ev
    // cycles between two clock-pin changes
    task automatic half(output int n);
        logic s;
        for (int i = 0; i < 2; i++) begin
            s = pinOut[3];
            n = 0;
            while (pinOut[3] === s && n < 4000) begin
                @(posedge sys_clk);
                n++;
            end
        end
    endtask : half
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (60000) @(posedge sys_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        {reset, sRst} = 2'b10;
        {haddr, htrans, hwrite, hwdata, noise, shape, base} = '0;
        num_errors = 0;
        checks = 0;
        void'($urandom(31));
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        noise <= $urandom();
        foreach (RA[i]) begin
            bus(1'b0, RA[i], 32'h0);
            `CHK(d, RV[i])
        end
        $display("test reset values done");
        bus(1'b1, spim_pkg::OFF_PSELCLK, 32'h3);
        bus(1'b1, spim_pkg::OFF_PSELMO, 32'h4);
        bus(1'b1, spim_pkg::OFF_PSELMI, 32'h5);
        bus(1'b1, spim_pkg::OFF_RATE, 32'h80000000);
        bus(1'b1, spim_pkg::OFF_IRQSET, 32'h0);
        bus(1'b0, spim_pkg::OFF_IRQSET, 32'h0);
        `CHK(d[0], 1'b0)
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, spim_pkg::OFF_ENABLE, 32'h0);
            bus(1'b1, spim_pkg::OFF_SHAPE, 32'(m));
            shape <= m[2:0];
            bus(1'b1, spim_pkg::OFF_ENABLE, 32'h1);
            sRst <= 1'b1;
            repeat (3) @(posedge sys_clk);
            sRst <= 1'b0;
            base <= 8'($urandom());
            b1 = 8'($urandom());
            b2 = 8'($urandom());
            bus(1'b1, spim_pkg::OFF_TXDATA, {24'h0, b1});
            if (m == 0) half(n8);
            bus(1'b1, spim_pkg::OFF_TXDATA, {24'h0, b2});
            `CHK(pinOe, 32'h18)
            wait_ev();
            // long enough for the second received byte to land in the waiting byte
            repeat (400) @(posedge sys_clk);
            bus(1'b1, spim_pkg::OFF_EVENT, 32'h0);
            bus(1'b0, spim_pkg::OFF_EVENT, 32'h0);
            `CHK(d[0], 1'b0)
            bus(1'b0, spim_pkg::OFF_RXDATA, 32'h0);
            `CHK(d[7:0], base)
            wait_ev();
            bus(1'b0, spim_pkg::OFF_RXDATA, 32'h0);
            `CHK(d[7:0], base + 8'h1)
            bus(1'b1, spim_pkg::OFF_EVENT, 32'h0);
            `CHK(rxPrev, b1)
            `CHK(rxLast, b2)
            `CHK(pinOut[3], shape[2])
            $display("test mode %0d done", m);
        end
        bus(1'b1, spim_pkg::OFF_RATE, 32'h02000000);
        bus(1'b1, spim_pkg::OFF_TXDATA, 32'h5A);
        half(n1);
        `CHK(n1, n8 * 64)
        wait_ev();
        bus(1'b1, spim_pkg::OFF_IRQSET, 32'h1);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        bus(1'b0, spim_pkg::OFF_IRQCLR, 32'h0);
        `CHK(d[0], 1'b1)
        bus(1'b1, spim_pkg::OFF_IRQCLR, 32'h1);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        bus(1'b1, spim_pkg::OFF_EVENT, 32'h0);
        bus(1'b1, spim_pkg::OFF_ENABLE, 32'h0);
        repeat (3) @(posedge sys_clk);
        `CHK(pinOe, 32'h0)
        $display("test rate and irq done");
        print_verdict();
    end
endmodule : test_spi_master_double_buffered
`default_nettype wire
